//--- verilog/afd_pkg.sv
// shared constants and types for the alpha-field character decoder
package afd_pkg;

  // ****************************************
  // scheme tags and special bytes
  // ****************************************
  localparam logic [7:0] AFD_TAG_PAIR = 8'h80;
  localparam logic [7:0] AFD_TAG_HALF = 8'h81;
  localparam logic [7:0] AFD_TAG_FULL = 8'h82;
  localparam logic [7:0] AFD_PAD_BYTE = 8'hff;

  // ****************************************
  // field positions
  // ****************************************
  localparam int AFD_OFS_FLAG_BIT = 7;
  localparam int AFD_HALF_SHIFT = 7;

  // ****************************************
  // values after reset, and the count decrement step
  // ****************************************
  localparam logic [15:0] AFD_CHAR_RST = 16'h0000;
  localparam logic [15:0] AFD_BASE_RST = 16'h0000;
  localparam logic [7:0] AFD_BYTE_RST = 8'h00;
  localparam logic [7:0] AFD_COUNT_RST = 8'h00;
  localparam logic [7:0] AFD_COUNT_ONE = 8'h01;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SCH_PLAIN = 2'b00,
    SCH_PAIR = 2'b01,
    SCH_HALF = 2'b10,
    SCH_FULL = 2'b11
  } afd_scheme_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_PAIR_HI = 4'b0001,
    ST_PAIR_LO = 4'b0010,
    ST_COUNT = 4'b0011,
    ST_BASE_HI = 4'b0100,
    ST_BASE_LO = 4'b0101,
    ST_CHARS = 4'b0110,
    ST_SKIP = 4'b0111,
    ST_PLAIN = 4'b1000
  } afd_state_e;

endpackage

//--- verilog/afd_out_reg.sv
// output register stage of the alpha-field character decoder
module afd_out_reg (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // next values
  input wire logic [15:0] charNxt,
  input wire logic validNxt,
  input wire logic ucsNxt,
  input wire logic doneNxt,
  // registered outputs
  output logic [15:0] char_r,
  output logic valid_r,
  output logic ucs_r,
  output logic done_r
);
  import afd_pkg::*;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      char_r <= AFD_CHAR_RST;
      valid_r <= 1'b0;
      ucs_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      char_r <= charNxt;
      valid_r <= validNxt;
      ucs_r <= ucsNxt;
      done_r <= doneNxt;
    end
  end

endmodule

//--- verilog/afd_decoder.sv
// alpha-field record decoder: record bytes in, 16-bit or 7-bit characters out
//
// What this block does
// (R01) tag 80: each following byte pair is one character, first byte is upper half
// (R02) tag 80: an FF FF pair after the last character is padding, never emitted
// (R03) tag 80: a lone final byte of an even-length field is filler, never paired
// (R04) tag 81: second byte gives the number of characters to emit
// (R05) tag 81: third byte forms base pointer bits 14..7, all other bits zero
// (R06) tag 81: character byte with top bit clear yields a 7-bit default character
// (R07) tag 81: top bit set adds low seven bits to base, giving a code point
// (R08) tag 82: second byte is count, third and fourth form the full base pointer
// (R09) tag 82: fifth byte onward decodes like the tag 81 character bytes
// (R10) counted schemes: FF inside the declared count is a real offset character
// (R11) one scheme per record, chosen by the first byte, never switched midway
// (R12) any other first byte: record is 7-bit default-alphabet characters, FF bytes dropped
// (R13) all three tagged schemes are handled for every character set size
// (R14) each character comes with a one-cycle strobe and a code-point flag
// (R15) done pulses once at count reached, tag 80 padding pair or record end, whichever comes first
module afd_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // record byte stream
  input wire logic [7:0] inByte,
  input wire logic inValid,
  input wire logic inLast,
  // decoded characters
  output logic [15:0] charOut,
  output logic charValid,
  output logic charIsUcs,
  // record status
  output logic recordDone
);
  import afd_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ****************************************
  // state
  // ****************************************
  afd_state_e state_r;
  afd_state_e stateNxt;
  afd_scheme_e scheme_r;
  afd_scheme_e schemeNxt;
  logic [7:0] hiByte_r;
  logic [7:0] hiByteNxt;
  logic [15:0] base_r;
  logic [15:0] baseNxt;
  logic [7:0] countLeft_r;
  logic [7:0] countLeftNxt;
  logic [15:0] charNxt;
  logic validNxt;
  logic ucsNxt;
  logic doneNxt;
  logic isTag;
  logic offsetByte;
  logic [15:0] offsetSum;
  logic [7:0] countDec;

  assign isTag = (inByte == AFD_TAG_PAIR) || (inByte == AFD_TAG_HALF) ||
                 (inByte == AFD_TAG_FULL);
  assign offsetByte = inByte[AFD_OFS_FLAG_BIT];
  // wraps within 16 bits, matching the code space
  assign offsetSum = base_r + {9'h000, inByte[6:0]};
  assign countDec = countLeft_r - AFD_COUNT_ONE;

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    stateNxt = state_r;
    schemeNxt = scheme_r;
    hiByteNxt = hiByte_r;
    baseNxt = base_r;
    countLeftNxt = countLeft_r;
    charNxt = charOut;
    validNxt = 1'b0;
    ucsNxt = charIsUcs;
    doneNxt = 1'b0;
    if (inValid) begin
      case (state_r)
        ST_IDLE: begin
          // the first byte alone fixes the scheme for the record
          if (inByte == AFD_TAG_PAIR) begin
            schemeNxt = SCH_PAIR; // [R11]
            stateNxt = inLast ? ST_IDLE : ST_PAIR_HI; // [R01]
            doneNxt = inLast;
          end else if (inByte == AFD_TAG_HALF) begin
            schemeNxt = SCH_HALF; // [R11] [R13]
            stateNxt = inLast ? ST_IDLE : ST_COUNT;
            doneNxt = inLast;
          end else if (inByte == AFD_TAG_FULL) begin
            schemeNxt = SCH_FULL; // [R11] [R13]
            stateNxt = inLast ? ST_IDLE : ST_COUNT;
            doneNxt = inLast;
          end else begin
            schemeNxt = SCH_PLAIN; // [R12]
            if (inByte != AFD_PAD_BYTE) begin
              charNxt = {9'h000, inByte[6:0]}; // [R12]
              validNxt = 1'b1; // [R14]
              ucsNxt = 1'b0;
            end
            stateNxt = inLast ? ST_IDLE : ST_PLAIN;
            doneNxt = inLast; // [R15]
          end
        end
        ST_PLAIN: begin
          // unused bytes of a plain record hold FF and are dropped
          if (inByte != AFD_PAD_BYTE) begin
            charNxt = {9'h000, inByte[6:0]}; // [R12]
            validNxt = 1'b1;
            ucsNxt = 1'b0;
          end
          if (inLast) begin
            stateNxt = ST_IDLE;
            doneNxt = 1'b1; // [R15]
          end
        end
        ST_PAIR_HI: begin
          hiByteNxt = inByte; // [R01]
          if (inLast) begin
            // odd byte left over: filler, never half a character
            stateNxt = ST_IDLE; // [R03]
            doneNxt = 1'b1; // [R15]
          end else begin
            stateNxt = ST_PAIR_LO;
          end
        end
        ST_PAIR_LO: begin
          if (hiByte_r == AFD_PAD_BYTE && inByte == AFD_PAD_BYTE) begin
            // first padding pair ends the text; rest is skipped
            doneNxt = 1'b1; // [R02]
            stateNxt = inLast ? ST_IDLE : ST_SKIP;
          end else begin
            charNxt = {hiByte_r, inByte}; // [R01]
            validNxt = 1'b1; // [R14]
            ucsNxt = 1'b1;
            doneNxt = inLast; // [R15]
            stateNxt = inLast ? ST_IDLE : ST_PAIR_HI;
          end
        end
        ST_COUNT: begin
          countLeftNxt = inByte; // [R04] [R08]
          doneNxt = inLast;
          stateNxt = inLast ? ST_IDLE : ST_BASE_HI;
        end
        ST_BASE_HI: begin
          if (scheme_r == SCH_HALF) begin
            baseNxt = {1'b0, inByte, 7'h00}; // [R05]
            if (inLast || countLeft_r == AFD_COUNT_RST) begin
              doneNxt = 1'b1; // [R15]
              stateNxt = inLast ? ST_IDLE : ST_SKIP;
            end else begin
              stateNxt = ST_CHARS; // [R06]
            end
          end else begin
            baseNxt = {inByte, base_r[7:0]}; // [R08]
            doneNxt = inLast;
            stateNxt = inLast ? ST_IDLE : ST_BASE_LO;
          end
        end
        ST_BASE_LO: begin
          baseNxt = {base_r[15:8], inByte}; // [R08]
          if (inLast || countLeft_r == AFD_COUNT_RST) begin
            doneNxt = 1'b1; // [R15]
            stateNxt = inLast ? ST_IDLE : ST_SKIP;
          end else begin
            stateNxt = ST_CHARS; // [R09]
          end
        end
        ST_CHARS: begin
          // FF here is an ordinary offset byte, not padding
          if (offsetByte) begin
            charNxt = offsetSum; // [R07] [R09] [R10]
            ucsNxt = 1'b1;
          end else begin
            charNxt = {9'h000, inByte[6:0]}; // [R06] [R09]
            ucsNxt = 1'b0;
          end
          validNxt = 1'b1; // [R14]
          countLeftNxt = countDec;
          if (countLeft_r == AFD_COUNT_ONE) begin
            doneNxt = 1'b1; // [R15]
            stateNxt = inLast ? ST_IDLE : ST_SKIP;
          end else if (inLast) begin
            doneNxt = 1'b1; // [R15]
            stateNxt = ST_IDLE;
          end
        end
        ST_SKIP: begin
          // bytes beyond the count are ignored until the record ends
          if (inLast) begin
            stateNxt = ST_IDLE;
          end
        end
        default: begin
          stateNxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      scheme_r <= SCH_PLAIN;
      hiByte_r <= AFD_BYTE_RST;
      base_r <= AFD_BASE_RST;
      countLeft_r <= AFD_COUNT_RST;
    end else begin
      state_r <= stateNxt;
      scheme_r <= schemeNxt;
      hiByte_r <= hiByteNxt;
      base_r <= baseNxt;
      countLeft_r <= countLeftNxt;
    end
  end

  // ****************************************
  // output registers
  // ****************************************
  afd_out_reg outStage (
    .sys_clk(sys_clk),
    .reset(reset),
    .charNxt(charNxt),
    .validNxt(validNxt),
    .ucsNxt(ucsNxt),
    .doneNxt(doneNxt),
    .char_r(charOut),
    .valid_r(charValid),
    .ucs_r(charIsUcs),
    .done_r(recordDone)
  );

  // ****************************************
  // assertions
  // ****************************************
  pair_char_a: assert property ( // [R01]
    state_r == ST_PAIR_LO && inValid && !(hiByte_r == AFD_PAD_BYTE && inByte == AFD_PAD_BYTE)
    |=> charValid && charIsUcs && charOut == {$past(hiByte_r), $past(inByte)})
    else $error("byte pair not joined into one character");

  pair_pad_a: assert property ( // [R02]
    state_r == ST_PAIR_LO && inValid && hiByte_r == AFD_PAD_BYTE && inByte == AFD_PAD_BYTE
    |=> !charValid && recordDone && state_r == ($past(inLast) ? ST_IDLE : ST_SKIP)
    ##1 (!charValid || $past(inLast, 2)))
    else $error("padding pair was emitted");

  odd_tail_a: assert property ( // [R03]
    state_r == ST_PAIR_HI && inValid && inLast |=> !charValid && recordDone)
    else $error("filler byte paired into a character");

  count_take_a: assert property ( // [R04]
    state_r == ST_COUNT && inValid && !inLast |=> countLeft_r == $past(inByte))
    else $error("character count not captured");

  half_base_a: assert property ( // [R05]
    state_r == ST_BASE_HI && scheme_r == SCH_HALF && inValid
    |=> base_r == {1'b0, $past(inByte), 7'h00})
    else $error("half-page base pointer wrong");

  dflt_char_a: assert property ( // [R06]
    state_r == ST_CHARS && inValid && !inByte[AFD_OFS_FLAG_BIT]
    |=> charValid && !charIsUcs && charOut == {9'h000, $past(inByte[6:0])})
    else $error("default character wrong");

  offset_char_a: assert property ( // [R07]
    state_r == ST_CHARS && inValid && inByte[AFD_OFS_FLAG_BIT]
    |=> charValid && charIsUcs && charOut == $past(base_r) + {9'h000, $past(inByte[6:0])})
    else $error("offset code point wrong");

  full_base_a: assert property ( // [R08]
    state_r == ST_BASE_HI && scheme_r == SCH_FULL && inValid && !inLast
    ##1 inValid && state_r == ST_BASE_LO
    |=> base_r == {$past(inByte, 2), $past(inByte)})
    else $error("full base pointer wrong");

  ff_counted_a: assert property ( // [R10]
    state_r == ST_CHARS && inValid && inByte == AFD_PAD_BYTE |=> charValid && charIsUcs)
    else $error("counted FF treated as padding");

  scheme_hold_a: assert property ( // [R11]
    state_r != ST_IDLE ##1 state_r != ST_IDLE |-> $stable(scheme_r))
    else $error("scheme changed inside a record");

  plain_rec_a: assert property ( // [R12]
    state_r == ST_IDLE && inValid && !isTag && inByte != AFD_PAD_BYTE
    |=> charValid && !charIsUcs && state_r != ST_PAIR_HI && state_r != ST_COUNT)
    else $error("untagged record not decoded as default alphabet");

  count_done_a: assert property ( // [R15]
    state_r == ST_CHARS && inValid && countLeft_r == AFD_COUNT_ONE
    |=> recordDone && charValid ##1 (!charValid || $past(inLast, 2)))
    else $error("done missing or character after count reached");

  // a one-byte record right behind another may legally give a second done
  done_pulse_a: assert property ( // [R15]
    recordDone && !(state_r == ST_IDLE && inValid && inLast) |=> !recordDone)
    else $error("done held longer than one cycle");

  pair_rec_c: cover property (
    state_r == ST_PAIR_LO && inValid ##1 charValid ##[1:8] recordDone);
  half_rec_c: cover property (
    scheme_r == SCH_HALF && state_r == ST_CHARS && inValid && inByte == AFD_PAD_BYTE);
  full_rec_c: cover property (
    scheme_r == SCH_FULL && state_r == ST_CHARS ##[1:20] recordDone);
  plain_rec_c: cover property (
    state_r == ST_PLAIN && inValid && inLast);

endmodule

//--- dv/afd_rec_model.sv
// record byte source and character sink facing the alpha-field decoder
module afd_rec_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // record byte stream toward the decoder
  output logic [7:0] inByte,
  output logic inValid,
  output logic inLast,
  // decoded characters from the decoder
  input wire logic [15:0] charOut,
  input wire logic charValid,
  input wire logic charIsUcs,
  input wire logic recordDone
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // consumer side capture
  // ****************************************
  logic [16:0] gotQ[$];
  int doneCnt;
  int doneCyc;
  int lastCyc;
  int cyc;

  initial begin
    inByte = 8'h00;
    inValid = 1'b0;
    inLast = 1'b0;
  end

  // cycle stamps let the bench judge the one-cycle answer latency
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (inValid && inLast) begin
      lastCyc <= cyc;
    end
    if (charValid === 1'b1 && !reset) begin
      gotQ.push_back({charIsUcs, charOut});
    end
    if (recordDone === 1'b1 && !reset) begin
      doneCnt <= doneCnt + 1;
      doneCyc <= cyc;
    end
  end

  // ****************************************
  // byte source
  // ****************************************
  // idle byte lane shows the inverse of the last byte, so a decoder that
  // samples without the valid qualifier picks up visible garbage
  task automatic send_rec(input logic [7:0] rec[$], input int gap);
    for (int i = 0; i < rec.size(); i++) begin
      @(posedge sys_clk);
      inByte <= rec[i];
      inValid <= 1'b1;
      inLast <= (i == rec.size() - 1);
      repeat (gap) begin
        @(posedge sys_clk);
        inValid <= 1'b0;
        inLast <= 1'b0;
        inByte <= ~rec[i];
      end
    end
    @(posedge sys_clk);
    inValid <= 1'b0;
    inLast <= 1'b0;
    inByte <= ~rec[rec.size() - 1];
  endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the alpha-field decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] inByte;
  logic inValid;
  logic inLast;
  logic [15:0] charOut;
  logic charValid;
  logic charIsUcs;
  logic recordDone;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] rec[$];
  logic [16:0] exp[$];

  always #4 sys_clk = ~sys_clk;

  afd_decoder uut (.sys_clk(sys_clk), .reset(reset), .inByte(inByte), .inValid(inValid),
    .inLast(inLast), .charOut(charOut), .charValid(charValid), .charIsUcs(charIsUcs),
    .recordDone(recordDone));

  afd_rec_model uSrc (.sys_clk(sys_clk), .reset(reset), .inByte(inByte), .inValid(inValid),
    .inLast(inLast), .charOut(charOut), .charValid(charValid), .charIsUcs(charIsUcs),
    .recordDone(recordDone));

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk_val(input string what, input logic [16:0] e, input logic [16:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_num(input string what, input int e, input int g);
    checks_done++;
    if (g != e) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one record in, captured characters and the single done pulse judged;
  // lag is done cycle minus the cycle that took the inLast byte
  task automatic run_rec(input string name, input int gap, input int lag);
    int done0;
    uSrc.gotQ.delete();
    done0 = uSrc.doneCnt;
    uSrc.send_rec(rec, gap);
    repeat (3) @(posedge sys_clk);
    chk_num({name, " char count"}, exp.size(), uSrc.gotQ.size());
    for (int i = 0; i < exp.size() && i < uSrc.gotQ.size(); i++) begin
      chk_val({name, " char"}, exp[i], uSrc.gotQ[i]);
    end
    chk_num({name, " done pulses"}, 1, uSrc.doneCnt - done0);
    chk_num({name, " done cycle"}, uSrc.lastCyc + lag, uSrc.doneCyc);
    $display("test %s finished, mismatches so far %0d", name, n_mismatch);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_pair();
    rec = '{8'h80, 8'h12, 8'h34, 8'h56, 8'h78, 8'hff, 8'hff};
    exp = '{17'h11234, 17'h15678};
    run_rec("pair", 0, 1);
    rec = '{8'h80, 8'hab, 8'hcd, 8'hff};
    exp = '{17'h1abcd};
    run_rec("pair even", 2, 1);
  endtask

  task automatic t_half();
    rec = '{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h7f, 8'hff, 8'hff};
    exp = '{17'h00053, 17'h10995, 17'h109a6, 17'h0007f, 17'h109ff};
    run_rec("half page", 0, 0);
  endtask

  task automatic t_full();
    rec = '{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3, 8'h2d, 8'h31};
    exp = '{17'h0002d, 17'h10532, 17'h10583, 17'h0002d, 17'h00031};
    run_rec("full base", 1, 1);
    rec = '{8'h82, 8'h01, 8'h12, 8'h34, 8'hff};
    exp = '{17'h112b3};
    run_rec("full ff", 0, 1);
  endtask

  task automatic t_plain();
    rec = '{8'h41, 8'h80, 8'h12, 8'hff, 8'hc1};
    exp = '{17'h00041, 17'h00000, 17'h00012, 17'h00041};
    run_rec("plain", 1, 1);
  endtask

  task automatic t_limits();
    rec = '{8'h81, 8'h02, 8'h13, 8'h95, 8'h41, 8'h55};
    exp = '{17'h10995, 17'h00041};
    run_rec("count cut", 0, 0);
    rec = '{8'h82, 8'h00, 8'h12, 8'h34, 8'h56};
    exp = {};
    run_rec("count zero", 0, 0);
    rec = '{8'h81, 8'h00, 8'h13, 8'h41};
    exp = {};
    run_rec("half zero", 0, 0);
    rec = '{8'h81, 8'h03};
    exp = {};
    run_rec("header cut", 0, 1);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_pair();
    t_half();
    t_full();
    t_plain();
    t_limits();
    print_verdict();
  end

  // whole run needs about 120 cycles; this bound is far above that
  initial begin
    #40000;
    n_mismatch++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
